// ==== src/pwr_event_route.sv ====
// wake and power-off event routing with apb registers
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pwr_event_route #(
  parameter int DEBOUNCE_CYC = pwr_pkg::DEBOUNCE_CYC
) (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // event pins
  input  wire pwr_pkg::pwr_pins_t pins,
  // outputs
  output logic               powerOnCtl,
  output logic               powerOffReq,
  output logic               sysCtlIrq,
  output logic               irq
);
  logic [31:0]         cfg1_q;
  logic [31:0]         cfg2_q;
  logic [31:0]         route_q;
  logic [pwr_pkg::ST_W-1:0] status_q;
  logic [pwr_pkg::ST_W-1:0] mask_q;
  logic [1:0]          ev_s;
  logic [1:0]          ev_prev_q;
  logic [1:0]          ri_s;
  logic [1:0]          ri_prev_q;
  logic                ringA_s;
  logic                ringB_s;
  logic                ringSel;
  logic                ringPrev_q;
  logic                sw_s;
  logic                swPrev_q;
  logic [1:0]          evHit;
  logic                riHit;
  logic                ringHit;
  logic                swHit;
  logic                onSet;
  logic                offSet;
  logic                sciSet;
  logic [pwr_pkg::ST_W-1:0] evVec;
  logic                offLevel_q;
  logic [2:0]          pulseCnt_q;
  logic                wrEn;
  logic                rdEn;
  logic                ctrlOnClr;
  logic                ctrlOffClr;

  function automatic logic rtBit(input logic [31:0] rt, input int idx, input int fld);
    rtBit = rt[idx*pwr_pkg::RT_W + fld];
  endfunction : rtBit

  // synchronisers: all pins are asynchronous to clk_sys
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      pwr_sync_filter #(.HOLD_CYC(1), .RST_VAL(1'b0)) u_ev (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .pinIn   (pins.event_in[gi]),
        .levelOut(ev_s[gi])
      );
      pwr_sync_filter #(.HOLD_CYC(1), .RST_VAL(1'b1)) u_ri (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .pinIn   (pins.ring_ind_b[gi]),
        .levelOut(ri_s[gi])
      );
    end
  endgenerate

  pwr_sync_filter #(.HOLD_CYC(1), .RST_VAL(1'b1)) u_ringa (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .pinIn   (pins.ring_a_b),
    .levelOut(ringA_s)
  );
  pwr_sync_filter #(.HOLD_CYC(1), .RST_VAL(1'b1)) u_ringb (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .pinIn   (pins.ring_b_b),
    .levelOut(ringB_s)
  );
  // long stable time swallows switch bounce
  pwr_sync_filter #(.HOLD_CYC(DEBOUNCE_CYC), .RST_VAL(1'b1)) u_sw (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .pinIn   (pins.switch_b),
    .levelOut(sw_s)
  );

  assign ringSel = cfg2_q[pwr_pkg::CFG2_RING_ALT] ? ringB_s : ringA_s;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ev_prev_q  <= 2'b00;
      ri_prev_q  <= 2'b11;
      ringPrev_q <= 1'b1;
      swPrev_q   <= 1'b1;
    end else begin
      ev_prev_q  <= ev_s;
      ri_prev_q  <= ri_s;
      ringPrev_q <= ringSel;
      swPrev_q   <= sw_s;
    end
  end

  // event detection per input
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      unique case (pwr_pkg::pwr_sense_t'(route_q[i*pwr_pkg::RT_W +: 2]))
        pwr_pkg::SENSE_LOW:  evHit[i] = !ev_s[i];
        pwr_pkg::SENSE_HIGH: evHit[i] = ev_s[i];
        pwr_pkg::SENSE_RISE: evHit[i] = ev_s[i] && !ev_prev_q[i];
        pwr_pkg::SENSE_FALL: evHit[i] = !ev_s[i] && ev_prev_q[i];
      endcase
      evHit[i] = evHit[i] && cfg1_q[pwr_pkg::CFG1_EN_EV0 + i];
    end
  end

  assign riHit   = (cfg1_q[pwr_pkg::CFG1_EN_RI0] && ri_prev_q[0] && !ri_s[0])
                || (cfg1_q[pwr_pkg::CFG1_EN_RI1] && ri_prev_q[1] && !ri_s[1]);
  // each falling edge of a pulse train re-arms the request
  assign ringHit = cfg1_q[pwr_pkg::CFG1_EN_RING] && ringPrev_q && !ringSel;
  assign swHit   = cfg1_q[pwr_pkg::CFG1_EN_SW] && swPrev_q && !sw_s;

  always_comb begin
    onSet  = riHit || ringHit;
    offSet = swHit;
    sciSet = 1'b0;
    for (int i = 0; i < 2; i++) begin
      onSet  = onSet  || (evHit[i] && rtBit(route_q, i, pwr_pkg::RT_ON));
      offSet = offSet || (evHit[i] && rtBit(route_q, i, pwr_pkg::RT_OFF));
      sciSet = sciSet || (evHit[i] && rtBit(route_q, i, pwr_pkg::RT_SCI));
    end
  end

  assign evVec = {swHit, ringHit, riHit, evHit};

  // apb: zero wait states
  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && !penable && !pwrite;
  assign ctrlOnClr  = wrEn && paddr == pwr_pkg::OFF_CTRL && pwdata[pwr_pkg::CTRL_ON_CLR];
  assign ctrlOffClr = wrEn && paddr == pwr_pkg::OFF_CTRL && pwdata[pwr_pkg::CTRL_OFF_CLR];

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cfg1_q  <= pwr_pkg::CFG1_RST;
      cfg2_q  <= pwr_pkg::CFG2_RST;
      route_q <= pwr_pkg::ROUTE_RST;
      mask_q  <= '0;
    end else if (wrEn) begin
      unique case (paddr)
        pwr_pkg::OFF_CFG1:  cfg1_q  <= pwdata;
        pwr_pkg::OFF_CFG2:  cfg2_q  <= pwdata;
        pwr_pkg::OFF_ROUTE: route_q <= pwdata;
        pwr_pkg::OFF_MASK:  mask_q  <= pwdata[pwr_pkg::ST_W-1:0];
        default: ;
      endcase
    end
  end

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~((wrEn && paddr == pwr_pkg::OFF_STATUS)
                  ? pwdata[pwr_pkg::ST_W-1:0] : '0)) | evVec;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_q & mask_q);
    end
  end

  // power-on request held until software releases it; set wins over clear
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      powerOnCtl <= 1'b0;
    end else if (onSet) begin
      powerOnCtl <= 1'b1;
    end else if (ctrlOnClr) begin
      powerOnCtl <= 1'b0;
    end
  end

  // system control interrupt set by the event inputs routed to it, held until either ctrl clear bit is written
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sysCtlIrq <= 1'b0;
    end else if (sciSet) begin
      sysCtlIrq <= 1'b1;
    end else if (ctrlOnClr || ctrlOffClr) begin
      sysCtlIrq <= 1'b0;
    end
  end

  // off request: level held until cleared, or fixed-width pulse
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      offLevel_q <= 1'b0;
    end else if (offSet) begin
      offLevel_q <= 1'b1;
    end else if (ctrlOffClr) begin
      offLevel_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pulseCnt_q <= '0;
    end else if (offSet) begin
      pulseCnt_q <= 3'(pwr_pkg::POR_PULSE_CYC);
    end else if (pulseCnt_q != 3'h0) begin
      pulseCnt_q <= pulseCnt_q - 3'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      powerOffReq <= 1'b0;
    end else if (cfg1_q[pwr_pkg::CFG1_POR_LEVEL]) begin
      powerOffReq <= offSet || offLevel_q;
    end else begin
      powerOffReq <= offSet || (pulseCnt_q > 3'h1);
    end
  end

  // read data registered in setup so access phase completes at once
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (rdEn) begin
      unique case (paddr)
        pwr_pkg::OFF_CFG1:   prdata <= cfg1_q;
        pwr_pkg::OFF_CFG2:   prdata <= cfg2_q;
        pwr_pkg::OFF_ROUTE:  prdata <= route_q;
        pwr_pkg::OFF_STATUS: prdata <= 32'(status_q);
        pwr_pkg::OFF_MASK:   prdata <= 32'(mask_q);
        pwr_pkg::OFF_STATE:  prdata <= {24'h00_0000, sw_s, ringSel, ri_s, ev_s,
                                        powerOffReq, powerOnCtl};
        default:             prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= !(paddr inside {pwr_pkg::OFF_CFG1, pwr_pkg::OFF_CFG2, pwr_pkg::OFF_ROUTE,
                   pwr_pkg::OFF_STATUS, pwr_pkg::OFF_MASK, pwr_pkg::OFF_CTRL,
                   pwr_pkg::OFF_STATE});
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end
endmodule : pwr_event_route
`default_nettype wire

// ==== src/pwr_pkg.sv ====
// package for the power event wake routing block
package pwr_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFF_CFG1   = 8'h00;
  localparam logic [7:0] OFF_CFG2   = 8'h04;
  localparam logic [7:0] OFF_ROUTE  = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_MASK   = 8'h10;
  localparam logic [7:0] OFF_CTRL   = 8'h14;
  localparam logic [7:0] OFF_STATE  = 8'h18;
  // first config fields
  localparam int CFG1_POR_LEVEL = 0;
  localparam int CFG1_EN_EV0    = 1;
  localparam int CFG1_EN_EV1    = 2;
  localparam int CFG1_EN_RI0    = 3;
  localparam int CFG1_EN_RI1    = 4;
  localparam int CFG1_EN_RING   = 5;
  localparam int CFG1_EN_SW     = 6;
  // second config fields
  localparam int CFG2_RING_ALT  = 0;
  // route field: per input, [1:0] sense, [2] off request, [3] interrupt, [4] power on
  localparam int RT_W           = 5;
  localparam int RT_OFF         = 2;
  localparam int RT_SCI         = 3;
  localparam int RT_ON          = 4;
  // status bits
  localparam int ST_EV0  = 0;
  localparam int ST_EV1  = 1;
  localparam int ST_RI   = 2;
  localparam int ST_RING = 3;
  localparam int ST_SW   = 4;
  localparam int ST_W    = 5;
  // ctrl bits
  localparam int CTRL_ON_CLR  = 0;
  localparam int CTRL_OFF_CLR = 1;
  // reset values
  localparam logic [31:0] CFG1_RST  = 32'h0000_0000;
  localparam logic [31:0] CFG2_RST  = 32'h0000_0000;
  localparam logic [31:0] ROUTE_RST = 32'h0000_0000;
  // timing
  localparam int CLK_MHZ        = 250;
  localparam int DEBOUNCE_MS    = 16;
  localparam int DEBOUNCE_CYC   = DEBOUNCE_MS * 1000 * CLK_MHZ;
  localparam int POR_PULSE_CYC  = 4;

  typedef enum logic [1:0] {
    SENSE_LOW  = 2'b00,
    SENSE_HIGH = 2'b01,
    SENSE_RISE = 2'b10,
    SENSE_FALL = 2'b11
  } pwr_sense_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } pwr_apb_req_t;

  typedef struct packed {
    logic [1:0] event_in;
    logic [1:0] ring_ind_b;
    logic       ring_a_b;
    logic       ring_b_b;
    logic       switch_b;
  } pwr_pins_t;
endpackage : pwr_pkg

// ==== src/pwr_sync_filter.sv ====
// three-stage pin synchroniser with optional stable-time debounce
`timescale 1ns/1ps
`default_nettype none
module pwr_sync_filter #(
  parameter int          HOLD_CYC = 1,
  parameter logic        RST_VAL  = 1'b1
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // pin and filtered level
  input  wire logic pinIn,
  output logic      levelOut
);
  localparam int CW = (HOLD_CYC > 1) ? $clog2(HOLD_CYC + 1) : 1;
  logic [2:0]    sync_q;
  logic [CW-1:0] cnt_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync_q <= {3{RST_VAL}};
    end else begin
      sync_q <= {sync_q[1:0], pinIn};
    end
  end

  // stage 0 is read only by stage 1; stages 1 and 2 must agree
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q    <= '0;
      levelOut <= RST_VAL;
    end else if (sync_q[1] != sync_q[2] || sync_q[2] == levelOut) begin
      cnt_q <= '0;
    end else if (cnt_q >= CW'(HOLD_CYC - 1)) begin
      cnt_q    <= '0;
      levelOut <= sync_q[2];
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end
endmodule : pwr_sync_filter
`default_nettype wire

// ==== test/pwr_supply_model.sv ====
// main supply model driven by the wake and off requests
`timescale 1ns/1ps
`default_nettype none
module pwr_supply_model (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // requests and supply state
  input  wire logic powerOnCtl,
  input  wire logic powerOffReq,
  output logic      supplyOn
);
  // off wins, so a stuck wake request cannot hold back a shutdown
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) supplyOn <= 1'b0;
    else if (powerOffReq) supplyOn <= 1'b0;
    else if (powerOnCtl) supplyOn <= 1'b1;
  end
endmodule : pwr_supply_model
`default_nettype wire

// ==== test/pwr_event_route_monitor.sv ====
// assertion checker for the power event routing block
`timescale 1ns/1ps
`default_nettype none
module pwr_event_route_monitor #(
  parameter int DEBOUNCE_CYC = 8
) (
  // clock, reset and apb
  input wire logic               clk_sys,
  input wire logic               rst_b,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  // pins and outputs
  input wire pwr_pkg::pwr_pins_t pins,
  input wire logic               powerOnCtl,
  input wire logic               powerOffReq,
  input wire logic               sysCtlIrq,
  input wire logic               irq
);
  logic [6:0] cfg1_q;
  logic       cfg2_q;
  logic [4:0] swLow_q;
  logic       offSeen_q;
  logic       wr;
  logic       clrOn;
  logic       clrOff;
  logic       ringPin;
  assign wr = psel && penable && pready && pwrite;
  assign clrOn = wr && paddr == pwr_pkg::OFF_CTRL && pwdata[0];
  assign clrOff = wr && paddr == pwr_pkg::OFF_CTRL && pwdata[1];
  assign ringPin = cfg2_q ? pins.ring_b_b : pins.ring_a_b;
  // shadow of the config, taken at the access edge like the block does
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) cfg1_q <= 7'h00;
    else if (wr && paddr == pwr_pkg::OFF_CFG1) cfg1_q <= pwdata[6:0];
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) cfg2_q <= 1'b0;
    else if (wr && paddr == pwr_pkg::OFF_CFG2) cfg2_q <= pwdata[0];
  end
  // press length, saturating, and whether an off request came during it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      swLow_q <= 5'h00;
      offSeen_q <= 1'b0;
    end else if (pins.switch_b) begin
      swLow_q <= 5'h00;
      offSeen_q <= 1'b0;
    end else begin
      swLow_q <= swLow_q + {4'h0, swLow_q != 5'h1F};
      offSeen_q <= offSeen_q | powerOffReq;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  AST_APB_READY: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_ON_HOLD: assert property (
    $fell(powerOnCtl) |-> $past(clrOn) || $past(clrOn, 2))
    else $error("power on dropped without clear");
  AST_OFF_PULSE: assert property (
    $rose(powerOffReq) && !cfg1_q[0] |-> powerOffReq [*4])
    else $error("off pulse too short");
  AST_OFF_LEVEL: assert property (
    powerOffReq && cfg1_q[0] |=> powerOffReq || $past(clrOff) || $past(clrOff, 2))
    else $error("off level dropped without clear");
  AST_RI_WAKE: assert property (
    ($fell(pins.ring_ind_b[0]) && cfg1_q[3]) || ($fell(pins.ring_ind_b[1]) && cfg1_q[4])
    |-> ##[1:6] powerOnCtl) else $error("ring indicator did not wake");
  AST_RING_WAKE: assert property ($fell(ringPin) && cfg1_q[5] |-> ##[1:6] powerOnCtl)
    else $error("ring pin did not wake");
  AST_WAKE_EN: assert property ($rose(powerOnCtl) |-> $past(|cfg1_q[5:1]))
    else $error("wake with all sources disabled");
  AST_SW_OFF: assert property (
    swLow_q == 5'(DEBOUNCE_CYC + 12) && cfg1_q[6] |-> offSeen_q)
    else $error("long press gave no off request");
endmodule : pwr_event_route_monitor
bind pwr_event_route pwr_event_route_monitor #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) mon (
  .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pins(pins), .powerOnCtl(powerOnCtl), .powerOffReq(powerOffReq),
  .sysCtlIrq(sysCtlIrq), .irq(irq));
`default_nettype wire

// ==== test/testbench.sv ====
// self-checking bench for the power event routing block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int DBC = 8;
  logic               clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, err, idle;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  pwr_pkg::pwr_pins_t pins;
  logic               powerOnCtl, powerOffReq, sysCtlIrq, irq, supplyOn;
  int                 seed, tgt, cnt, bad_count, num_checks;
  pwr_event_route #(.DEBOUNCE_CYC(DBC)) dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .powerOnCtl(powerOnCtl), .powerOffReq(powerOffReq), .sysCtlIrq(sysCtlIrq), .irq(irq));
  pwr_supply_model sup (.clk_sys(clk_sys), .rst_b(rst_b), .powerOnCtl(powerOnCtl),
    .powerOffReq(powerOffReq), .supplyOn(supplyOn));
  always #2 clk_sys = ~clk_sys;
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  // one apb transfer, held until pready; an edge passes before the next setup
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge clk_sys);
    end
    if (n == 16) begin
      bad_count++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  initial begin
    clk_sys = 1'b0;
    seed = 92;
    bad_count = 0;
    num_checks = 0;
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    pins = 7'h1F;
    cyc(2);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    chk({powerOnCtl, powerOffReq, sysCtlIrq, irq}, 32'h0000_0000);
    apb(1'b0, pwr_pkg::OFF_ROUTE, 32'h0000_0000);
    chk(rd, pwr_pkg::ROUTE_RST);
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
    $display("reset test done");
    for (int s = 0; s < 4; s++) begin
      for (int e = 0; e < 2; e++) begin
        for (int en = 0; en < 2; en++) begin
          tgt = {$random(seed)} % 3;
          idle = (s == 0 || s == 3);
          pins.event_in[e] <= idle;
          cyc(6);
          apb(1'b1, pwr_pkg::OFF_ROUTE, (32'(s) | 32'h1 << (pwr_pkg::RT_OFF + tgt)) << (5 * e));
          apb(1'b1, pwr_pkg::OFF_CFG1, 32'h1 | 32'(en) << (1 + e));
          pins.event_in[e] <= !idle;
          cyc(8);
          chk({powerOffReq, sysCtlIrq, powerOnCtl}, en ? 3'h4 >> tgt : 3'h0);
          pins.event_in[e] <= idle;
          cyc(6);
          apb(1'b1, pwr_pkg::OFF_CTRL, 32'h0000_0003);
          apb(1'b1, pwr_pkg::OFF_STATUS, 32'h0000_001F);
        end
      end
    end
    $display("event routing test done");
    apb(1'b1, pwr_pkg::OFF_ROUTE, 32'h0000_000B);
    apb(1'b1, pwr_pkg::OFF_CFG1, 32'h0000_0003);
    pins.event_in[0] <= 1'b0;
    cyc(8);
    chk({sysCtlIrq, irq}, 32'h0000_0002);
    apb(1'b1, pwr_pkg::OFF_MASK, 32'h0000_0001);
    // irq is registered one edge after the mask lands
    cyc(1);
    chk({sysCtlIrq, irq}, 32'h0000_0003);
    apb(1'b1, pwr_pkg::OFF_STATUS, 32'h0000_0001);
    apb(1'b1, pwr_pkg::OFF_CTRL, 32'h0000_0003);
    chk({sysCtlIrq, irq}, 32'h0000_0000);
    $display("interrupt test done");
    apb(1'b1, pwr_pkg::OFF_CFG1, 32'h0000_0019);
    for (int i = 0; i < 2; i++) begin
      pins.ring_ind_b[i] <= 1'b0;
      cyc(8);
      chk({supplyOn, powerOnCtl}, 32'h0000_0003);
      pins.ring_ind_b[i] <= 1'b1;
      apb(1'b1, pwr_pkg::OFF_CTRL, 32'h0000_0001);
    end
    apb(1'b1, pwr_pkg::OFF_CFG1, 32'h0000_0021);
    for (int sel = 0; sel < 2; sel++) begin
      apb(1'b1, pwr_pkg::OFF_CFG2, 32'(sel));
      for (int p = 0; p < 2; p++) begin
        repeat (3) begin
          pins[2 - p] <= 1'b0;
          cyc(3);
          pins[2 - p] <= 1'b1;
          cyc(3);
        end
        cyc(4);
        chk(powerOnCtl, p == sel);
        apb(1'b1, pwr_pkg::OFF_CTRL, 32'h0000_0001);
      end
    end
    $display("ring wake test done");
    apb(1'b1, pwr_pkg::OFF_CFG1, 32'h0000_0041);
    pins.switch_b <= 1'b0;
    cyc(3);
    pins.switch_b <= 1'b1;
    cyc(20);
    chk(powerOffReq, 1'b0);
    pins.switch_b <= 1'b0;
    cyc(DBC + 16);
    chk(powerOffReq, 1'b1);
    pins.switch_b <= 1'b1;
    cyc(DBC + 8);
    chk(powerOffReq, 1'b1);
    apb(1'b1, pwr_pkg::OFF_CTRL, 32'h0000_0002);
    cyc(1);
    chk(powerOffReq, 1'b0);
    apb(1'b1, pwr_pkg::OFF_CFG1, 32'h0000_0040);
    cnt = 0;
    pins.switch_b <= 1'b0;
    repeat (40) begin
      @(posedge clk_sys);
      cnt += int'(powerOffReq === 1'b1);
    end
    chk(cnt, pwr_pkg::POR_PULSE_CYC);
    pins.switch_b <= 1'b1;
    $display("switch test done");
    results();
  end
endmodule : testbench
`default_nettype wire
